/* File: design/atms_defs.svh */
// Purpose: Constants for the auxiliary and temperature measurement sequencer.
// Assumes: Internal oscillator modelled as clk at 100 MHz.
// Notes:   Counts are in clk cycles; half cycles are rounded up to whole cycles.
`ifndef ATMS_DEFS_SVH
`define ATMS_DEFS_SVH
`define ATMS_FN_AUX_SINGLE   4'h5
`define ATMS_FN_TEMP_FIRST   4'h6
`define ATMS_FN_TEMP_SECOND  4'h7
`define ATMS_FN_AUX_CONT     4'h8
`define ATMS_FN_XSCAN        4'h1
`define ATMS_FN_YSCAN        4'h2
// Overhead of 3.5 cycles held as seven half cycles, rounded up to 4 whole cycles.
`define ATMS_AUX_OH_HALF     8'h07
`define ATMS_AUX_OH_CYC      8'(( `ATMS_AUX_OH_HALF + 8'h01) >> 1)
`define ATMS_CONV_OH_CYC     8'h03
`define ATMS_CLK_RATIO       8'h02
`define ATMS_RES_BITS        8'h0C
`define ATMS_NUM_CONV        8'h01
`define ATMS_PREPROC_LAT     8'h02
`define ATMS_STAB_DLY        8'h10
`endif

/* File: design/atms_pkg.sv */
// Purpose: Types for the auxiliary and temperature measurement sequencer.
// Assumes: Nothing beyond the constants header.
// Notes:   None.
`default_nettype none
package atms_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_OVERHEAD, ST_DRVON, ST_CONV, ST_PREPROC, ST_LOAD} atms_state_t;
  typedef struct packed {
    logic        valid;
    logic [3:0]  func;
  } atms_cmd_t;
endpackage
`default_nettype wire

/* File: design/aux_temp_measure_sequencer.sv */
// Purpose: Times auxiliary, temperature and host-driven scan conversions.
// Assumes: Command arrives decoded from the serial link, on clk.
// Notes: panel drivers and converter are external; this block sequences them.
// Notes on behaviour
// (R1) Code 0101 starts one auxiliary measurement that does not repeat.
// (R2) Code 1000 repeats auxiliary measurements until another code is given.
// (R3) Code 0110 starts the first temperature measurement.
// (R4) Code 0111 starts the second temperature measurement.
// (R5) Temperature measurements use the same sequence and length as the single auxiliary one.
// (R6) A measurement is 3.5 cycles overhead, then N conversions, then preprocessing latency.
// (R7) In host-driven scan mode, drivers found off are switched on by the device before the scan.
// (R8) When the device switches drivers on itself it waits the stabilization delay first.
// (R9) Each conversion carries three extra oscillator cycles of overhead.
// (R10) In host-driven scan mode the interrupt pin only shows pen touch.
// (R11) At the end the result is loaded and only then data-ready is raised.
`include "atms_defs.svh"
`default_nettype none
module aux_temp_measure_sequencer (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire atms_pkg::atms_cmd_t cmd,
  input  wire logic              hostDrivenScanMode,
  input  wire logic              driversOn,
  input  wire logic              penTouch,
  input  wire logic [11:0]       convData,
  output logic                   driverEnable,
  output logic                   sampleStrobe,
  output logic                   busy,
  output logic [11:0]            resultData,
  output logic                   dataReady,
  output logic                   penIrqDataReadyPin
);
  atms_pkg::atms_state_t stateQ;
  logic [7:0]  cntQ;
  logic [7:0]  convLeftQ;
  logic [3:0]  funcQ;
  logic        contQ;
  logic        driverEnableQ;
  logic        sampleQ;
  logic        busyQ;
  logic [11:0] resultQ;
  logic        dataReadyQ;
  logic        pinQ;
  logic        penS1Q;
  logic        penS2Q;
  logic        drvS1Q;
  logic        drvS2Q;
  logic        isMeas;
  logic        isScan;
  logic [7:0]  convLen;

  assign isMeas = cmd.valid && (cmd.func == `ATMS_FN_AUX_SINGLE || cmd.func == `ATMS_FN_AUX_CONT
                  || cmd.func == `ATMS_FN_TEMP_FIRST || cmd.func == `ATMS_FN_TEMP_SECOND); // R1 R2 R3 R4
  assign isScan = cmd.valid && hostDrivenScanMode
                  && (cmd.func == `ATMS_FN_XSCAN || cmd.func == `ATMS_FN_YSCAN);
  // Bit cycles then the fixed conversion overhead.
  assign convLen = 8'((`ATMS_RES_BITS + 8'h02) * `ATMS_CLK_RATIO + `ATMS_CONV_OH_CYC); // R9

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      penS1Q <= 1'b0;
      penS2Q <= 1'b0;
      drvS1Q <= 1'b0;
      drvS2Q <= 1'b0;
    end else begin
      penS1Q <= penTouch;
      penS2Q <= penS1Q;
      drvS1Q <= driversOn;
      drvS2Q <= drvS1Q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ    <= atms_pkg::ST_IDLE;
      cntQ      <= 8'h00;
      convLeftQ <= 8'h00;
      funcQ     <= 4'h0;
      contQ     <= 1'b0;
    end else begin
      // Any code other than 1000 ends continuous mode.
      // The function is latched only from idle, so a code refused while busy cannot suppress data-ready.
      if (cmd.valid) begin
        contQ <= cmd.func == `ATMS_FN_AUX_CONT; // R2
      end
      case (stateQ)
        atms_pkg::ST_IDLE: begin
          if (cmd.valid) begin
            funcQ <= cmd.func; // R11
          end
          if (isMeas) begin
            stateQ <= atms_pkg::ST_OVERHEAD; // R5
            cntQ   <= `ATMS_AUX_OH_CYC; // R6
          end else if (isScan && !drvS2Q) begin
            stateQ <= atms_pkg::ST_DRVON; // R7
            cntQ   <= `ATMS_STAB_DLY; // R8
          end else if (isScan) begin
            stateQ    <= atms_pkg::ST_CONV;
            cntQ      <= convLen;
            convLeftQ <= `ATMS_NUM_CONV;
          end
        end
        atms_pkg::ST_DRVON, atms_pkg::ST_OVERHEAD: begin
          if (cntQ == 8'h01) begin
            stateQ    <= atms_pkg::ST_CONV; // R8
            cntQ      <= convLen;
            convLeftQ <= `ATMS_NUM_CONV;
          end else begin
            cntQ <= cntQ - 8'h01;
          end
        end
        atms_pkg::ST_CONV: begin
          if (cntQ == 8'h01) begin
            if (convLeftQ == 8'h01) begin
              stateQ <= atms_pkg::ST_PREPROC; // R6
              cntQ   <= `ATMS_PREPROC_LAT;
            end else begin
              convLeftQ <= convLeftQ - 8'h01;
              cntQ      <= convLen;
            end
          end else begin
            cntQ <= cntQ - 8'h01;
          end
        end
        atms_pkg::ST_PREPROC: begin
          if (cntQ == 8'h01) begin
            stateQ <= atms_pkg::ST_LOAD;
          end else begin
            cntQ <= cntQ - 8'h01;
          end
        end
        atms_pkg::ST_LOAD: begin
          if (contQ && !(cmd.valid && cmd.func != `ATMS_FN_AUX_CONT)) begin
            stateQ <= atms_pkg::ST_OVERHEAD; // R2
            cntQ   <= `ATMS_AUX_OH_CYC;
          end else begin
            stateQ <= atms_pkg::ST_IDLE; // R1
          end
        end
        default: stateQ <= atms_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driverEnableQ <= 1'b0;
      sampleQ       <= 1'b0;
      busyQ         <= 1'b0;
    end else begin
      if (stateQ == atms_pkg::ST_DRVON) begin
        driverEnableQ <= 1'b1; // R7
      end else if (stateQ == atms_pkg::ST_IDLE && drvS2Q) begin
        driverEnableQ <= 1'b0;
      end
      sampleQ <= stateQ == atms_pkg::ST_CONV && cntQ == 8'h01;
      busyQ   <= stateQ != atms_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resultQ    <= 12'h000;
      dataReadyQ <= 1'b0;
      pinQ       <= 1'b1;
    end else begin
      if (sampleQ) begin
        resultQ <= convData;
      end
      // Result settles during PREPROC; the flag rises the cycle after LOAD.
      dataReadyQ <= stateQ == atms_pkg::ST_LOAD && funcQ != `ATMS_FN_XSCAN && funcQ != `ATMS_FN_YSCAN; // R11
      if (hostDrivenScanMode) begin
        pinQ <= !penS2Q; // R10
      end else begin
        pinQ <= !(penS2Q || dataReadyQ);
      end
    end
  end

  assign driverEnable       = driverEnableQ;
  assign sampleStrobe       = sampleQ;
  assign busy               = busyQ;
  assign resultData         = resultQ;
  assign dataReady          = dataReadyQ;
  assign penIrqDataReadyPin = pinQ;

  a_meas_start_ovh: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_IDLE && isMeas) |=> stateQ == atms_pkg::ST_OVERHEAD && cntQ == 8'h04) // R6
    else $error("measurement did not start with overhead");
  a_temp_same_seq: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_IDLE && cmd.valid && cmd.func == `ATMS_FN_TEMP_FIRST) |=> stateQ == atms_pkg::ST_OVERHEAD) // R3
    else $error("temperature first not sequenced");
  a_temp_measure_second_seq: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_IDLE && cmd.valid && cmd.func == `ATMS_FN_TEMP_SECOND) |=> stateQ == atms_pkg::ST_OVERHEAD) // R4
    else $error("temperature second not sequenced");
  a_ovh_to_conv: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_OVERHEAD && $past(stateQ) == atms_pkg::ST_IDLE) |-> ##4 stateQ == atms_pkg::ST_CONV) // R5
    else $error("overhead length wrong");
  a_conv_len: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_CONV && $changed(stateQ)) |-> cntQ == 8'h1F) // R9
    else $error("conversion length wrong");
  a_drv_autoon: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_IDLE && isScan && !drvS2Q) |=> stateQ == atms_pkg::ST_DRVON ##1 driverEnable) // R7
    else $error("drivers not switched on");
  a_stab_delay: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_DRVON && $changed(stateQ)) |-> stateQ == atms_pkg::ST_DRVON [*8]) // R8
    else $error("stabilization delay cut short");
  a_single_ends: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_LOAD && funcQ == `ATMS_FN_AUX_SINGLE) |=> stateQ == atms_pkg::ST_IDLE) // R1
    else $error("single measurement repeated");
  a_cont_repeat: assert property (@(posedge clk) disable iff (!rst_n)
    (stateQ == atms_pkg::ST_LOAD && contQ && !cmd.valid) |=> stateQ == atms_pkg::ST_OVERHEAD) // R2
    else $error("continuous measurement stopped");
  a_ready_after: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dataReady) |-> $past(stateQ) == atms_pkg::ST_LOAD) // R11
    else $error("data ready without load");
  a_pin_pen_only: assert property (@(posedge clk) disable iff (!rst_n)
    (hostDrivenScanMode && $past(hostDrivenScanMode)) |-> penIrqDataReadyPin == !$past(penS2Q)) // R10
    else $error("pin shows more than pen touch");
  c_aux_single: cover property (@(posedge clk) disable iff (!rst_n) $rose(dataReady) && funcQ == `ATMS_FN_AUX_SINGLE);
  c_aux_cont: cover property (@(posedge clk) disable iff (!rst_n) stateQ == atms_pkg::ST_LOAD && contQ);
  c_temp: cover property (@(posedge clk) disable iff (!rst_n) $rose(dataReady) && funcQ == `ATMS_FN_TEMP_SECOND);
  c_drvon: cover property (@(posedge clk) disable iff (!rst_n) stateQ == atms_pkg::ST_DRVON);
endmodule // aux_temp_measure_sequencer
`default_nettype wire

/* File: verif/atms_panel_model.sv */
// Purpose: Panel driver model; reports drivers on two cycles after any party enables them.
// Assumes: Host enable and device enable are OR-ed at the panel.
// Notes:   Drivers go off as soon as both enables drop.
`default_nettype none
module atms_panel_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hostDrv,
  input  wire logic driverEnable,
  output logic      driversOn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= 2'h0;
    end else begin
      dly_q <= {dly_q[0], hostDrv | driverEnable};
    end
  end
  assign driversOn = dly_q[1] & (hostDrv | driverEnable);
endmodule // atms_panel_model
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the measurement sequencer.
// Assumes: Latency reckoned from the take edge to the edge that raises dataReady.
// Notes:   Converter data changes every cycle so a late or early sample shows.
`include "atms_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  atms_pkg::atms_cmd_t cmd = '0;
  logic                scanMode = 1'b0;
  logic                hostDrv = 1'b0;
  logic                penTouch = 1'b0;
  logic [11:0]         convData = 12'h000;
  logic                driversOn, driverEnable, sampleStrobe, busy, dataReady, penPin, deSeen, pinLow;
  logic [11:0]         resultData, capData;
  int                  seed = 44;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  int                  n, t1, t2, pulses, ts;
  always #5 clk = ~clk;
  always @(posedge clk) convData <= 12'($random(seed));
  aux_temp_measure_sequencer uut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .hostDrivenScanMode(scanMode),
    .driversOn(driversOn), .penTouch(penTouch), .convData(convData), .driverEnable(driverEnable),
    .sampleStrobe(sampleStrobe), .busy(busy), .resultData(resultData), .dataReady(dataReady),
    .penIrqDataReadyPin(penPin));
  atms_panel_model panel (.clk(clk), .rst_n(rst_n), .hostDrv(hostDrv), .driverEnable(driverEnable),
    .driversOn(driversOn));
  function automatic int conv_cycles();
    return (int'(`ATMS_RES_BITS) + 2) * int'(`ATMS_CLK_RATIO) + int'(`ATMS_CONV_OH_CYC);
  endfunction
  function automatic int sample_cycles();
    return int'(`ATMS_AUX_OH_CYC) + int'(`ATMS_NUM_CONV) * conv_cycles();
  endfunction
  // One cycle in the load state, then the registered flag rises.
  function automatic int meas_cycles();
    return sample_cycles() + int'(`ATMS_PREPROC_LAT) + 1;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send(input logic [3:0] code);
    @(posedge clk);
    cmd <= '{valid: 1'b1, func: code};
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic wait_on(input int which);
    n = 0;
    ts = -1;
    deSeen = 1'b0;
    pinLow = 1'b0;
    pulses = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      deSeen |= (driverEnable === 1'b1);
      pinLow |= (penPin === 1'b0);
      if (dataReady === 1'b1) pulses++;
      if (sampleStrobe === 1'b1) begin
        ts = n;
        capData = convData;
      end
    end while (n < 200 && ((which == 0 && dataReady !== 1'b1) || (which == 1 && sampleStrobe !== 1'b1) ||
                           (which == 2 && busy !== 1'b0)));
    if (n >= 200) begin
      bad_count++;
      $display("BAD wait %0d expected done seen timeout", which);
    end
  endtask
  task automatic measure(input logic [3:0] code);
    send(code);
    wait_on(0);
    check("sample time", sample_cycles(), ts);
    check("latency", meas_cycles(), n);
    check("result", 32'(capData), 32'(resultData));
    wait_on(2);
  endtask
  initial begin
    #50000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    check("pin idle", 1, 32'(penPin));
    measure(`ATMS_FN_AUX_SINGLE);
    check("no repeat", 0, 32'(busy));
    measure(`ATMS_FN_TEMP_FIRST);
    measure(`ATMS_FN_TEMP_SECOND);
    repeat (6) measure(4'h5 + 4'($unsigned($random(seed)) % 3));
    send(`ATMS_FN_AUX_CONT);
    repeat (2) wait_on(0);
    check("cont second", 1, 32'(dataReady));
    check("cont period", meas_cycles(), n);
    send(`ATMS_FN_AUX_SINGLE);
    wait_on(2);
    check("cont stop", 0, 32'(busy));
    scanMode <= 1'b1;
    hostDrv <= 1'b1;
    repeat (5) @(posedge clk);
    send(`ATMS_FN_XSCAN);
    wait_on(1);
    t1 = n;
    check("host drv", 0, 32'(deSeen));
    check("scan time", conv_cycles(), t1);
    wait_on(2);
    check("scan ready", 0, 32'(pulses));
    measure(`ATMS_FN_AUX_SINGLE);
    check("scan pin", 0, 32'(pinLow));
    hostDrv <= 1'b0;
    repeat (5) @(posedge clk);
    send(`ATMS_FN_YSCAN);
    wait_on(1);
    t2 = n;
    check("auto drv", 1, 32'(deSeen));
    check("stab delay", t1 + int'(`ATMS_STAB_DLY), t2);
    wait_on(2);
    penTouch <= 1'b1;
    repeat (6) @(posedge clk);
    check("pen low", 0, 32'(penPin));
    penTouch <= 1'b0;
    repeat (6) @(posedge clk);
    check("pen high", 1, 32'(penPin));
    print_verdict();
  end
endmodule // tb
`default_nettype wire
